// [hdl/ndcr_pkg.sv]
// Package for the nibble debug and control register bank.
// Assumes a 16-bit register port on one 50 MHz clock.
package ndcr_pkg;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 16;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [5:0] OFF_NIBBLE_FIRST  = 6'h00;
	localparam logic [5:0] OFF_NIBBLE_SECOND = 6'h01;
	localparam logic [5:0] OFF_CALIB         = 6'h02;
	localparam logic [5:0] OFF_DBG_WRITE     = 6'h37;
	localparam logic [5:0] OFF_DBG_INDEX     = 6'h38;
	localparam logic [5:0] OFF_DBG_READ      = 6'h39;
	localparam logic [5:0] OFF_DBG_COUNTER   = 6'h3A;

	// ************************************************************
	// Fields and reset values
	// ************************************************************
	localparam int unsigned NC0_POS_NB   = 0;
	localparam int unsigned NC0_NEG_NB   = 1;
	localparam int unsigned NC0_INV_RX   = 2;
	localparam int unsigned NC0_SERIAL   = 3;
	localparam int unsigned NC0_TX_GATE  = 4;
	localparam int unsigned NC0_RX_GATE  = 5;
	localparam int unsigned NC0_RXG_EXT  = 6;
	localparam int unsigned NC0_W        = 7;
	localparam int unsigned NC1_PH_P     = 0;
	localparam int unsigned NC1_PH_N     = 1;
	localparam int unsigned NC1_TX_LO    = 2;
	localparam int unsigned NC1_W        = 12;
	localparam int unsigned TX_COUNT     = 10;
	localparam int unsigned CAL_ON       = 0;
	localparam int unsigned CAL_IN_OFF   = 1;
	localparam int unsigned CAL_OUT_OFF  = 2;
	localparam int unsigned CAL_W        = 3;
	localparam int unsigned WR_SEL_HI    = 15;
	localparam int unsigned WR_SEL_LO    = 8;
	localparam int unsigned SEL_OTHER    = 7;
	localparam int unsigned CNT_GO       = 0;

	localparam logic [6:0]  NC0_RESET    = 7'h00;
	localparam logic [11:0] NC1_RESET    = 12'h000;
	localparam logic [2:0]  CAL_RESET    = 3'h1;
	localparam logic [15:0] IDX_RESET    = 16'h0000;
	localparam logic [15:0] ZERO_WORD    = 16'h0000;
	localparam logic [7:0]  SEL_NONE     = 8'h00;
endpackage

// [hdl/ndcr_regs.sv]
// Nibble debug multiplexer and nibble/calibration control registers.
// Assumes a synchronous master on clk_i; status sources on clk_i.
//
// Function
// - Index upper byte picks debug write target: none, calibration engine, others.
// - Index lower byte picks debug read source: calibration engine or others.
// - Read-only debug read word at 0x39, reset zero, shows selected source.
// - Bit 0 at 0x3A starts debug counter; other bits reserved; reset zero.
// - Addresses 0x3B to 0x3F decode nothing; writes change no state.
// - Nibble control first bit 0 feeds positive quarter delay from neighbour.
// - Nibble control first bit 1 feeds negative quarter delay from neighbour.
// - Nibble control first bit 2 inverts pad-to-receive clock path.
// - Nibble control first bit 3 puts receive paths into serial sampling.
// - Nibble control first bit 4 disables transmit clock gating.
// - Nibble control first bit 5 disables receive clock gating.
// - Nibble control second bits 0 and 1 shift received clock 90 degrees.
// - Nibble control second bits 2 to 11 delay each transmitter 90 degrees.
// - Calibration control bit 0 turns self-calibration on; on by default.
// - Calibration control bit 1 set disables input delay drift tracking.
// - Calibration control bit 2 set disables output delay drift tracking.
// - Debug write word at 0x37 passes writes to the write target; reads show write-path status, reset zero.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module ndcr_regs
	import ndcr_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	input  wire logic [DATA_W-1:0] calib_status_i,
	input  wire logic [DATA_W-1:0] other_status_i,
	input  wire logic [DATA_W-1:0] write_status_i,
	input  wire logic              delay_ready_flag_i,
	output logic      [DATA_W-1:0] dbg_wdata_o,
	output logic                   dbg_calib_wr_o,
	output logic                   dbg_other_wr_o,
	output logic      [7:0]        debug_write_target_select_o,
	output logic                   debug_counter_go_o,
	output logic                   pos_strobe_from_neighbour_o,
	output logic                   neg_strobe_from_neighbour_o,
	output logic                   invert_rx_clock_o,
	output logic                   serial_mode_o,
	output logic                   tx_gating_off_o,
	output logic                   rx_gating_off_o,
	output logic                   rx_gate_extend_o,
	output logic                   rx_phase_pos_o,
	output logic                   rx_phase_neg_o,
	output logic      [TX_COUNT-1:0] tx_phase_90_o,
	output logic                   built_in_self_calibration_o,
	output logic                   input_drift_tracking_off_o,
	output logic                   output_drift_tracking_off_o
);

	// ************************************************************
	// Decode helpers
	// ************************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	function automatic logic is_other(input logic [7:0] sel);
		is_other = sel[SEL_OTHER];
	endfunction

	logic [NC0_W-1:0]  nc0_reg;
	logic [NC1_W-1:0]  nc1_reg;
	logic [CAL_W-1:0]  cal_reg;
	logic [DATA_W-1:0] idx_reg;
	logic              go_reg;
	logic [DATA_W-1:0] rd_word_reg;
	logic [DATA_W-1:0] wr_word_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic [DATA_W-1:0] dbgw_reg;
	logic              calw_reg;
	logic              othw_reg;
	logic              rdy_s1_reg;
	logic              rdy_s2_reg;
	logic              rdy_s3_reg;
	logic [7:0]        wsel;
	logic [7:0]        rsel;
	logic [7:0]        rsel_next;

	assign wsel = idx_reg[WR_SEL_HI:WR_SEL_LO];
	assign rsel = idx_reg[WR_SEL_LO-1:0];
	// selector counts in the cycle of its own write, so a gapless read sees it
	assign rsel_next = (wr_i && hit(addr_i, OFF_DBG_INDEX)) ? wdata_i[WR_SEL_LO-1:0] : rsel;

	// ************************************************************
	// Control registers
	// ************************************************************
	// Delay-ready is asynchronous to us; rising edge seen past two flops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdy_s1_reg <= 1'b0;
			rdy_s2_reg <= 1'b0;
			rdy_s3_reg <= 1'b0;
		end else begin
			rdy_s1_reg <= delay_ready_flag_i;
			rdy_s2_reg <= rdy_s1_reg;
			rdy_s3_reg <= rdy_s2_reg;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nc0_reg <= NC0_RESET;
		end else if (wr_i && hit(addr_i, OFF_NIBBLE_FIRST)) begin
			nc0_reg <= wdata_i[NC0_W-1:0];
		end else if (rdy_s2_reg && !rdy_s3_reg) begin
			nc0_reg[NC0_SERIAL] <= NC0_RESET[NC0_SERIAL];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			nc1_reg <= NC1_RESET;
		end else if (wr_i && hit(addr_i, OFF_NIBBLE_SECOND)) begin
			nc1_reg <= wdata_i[NC1_W-1:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cal_reg <= CAL_RESET;
		end else if (wr_i && hit(addr_i, OFF_CALIB)) begin
			cal_reg <= wdata_i[CAL_W-1:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			idx_reg <= IDX_RESET;
		end else if (wr_i && hit(addr_i, OFF_DBG_INDEX)) begin
			idx_reg <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			go_reg <= 1'b0;
		end else if (wr_i && hit(addr_i, OFF_DBG_COUNTER)) begin
			go_reg <= wdata_i[CNT_GO];
		end
	end

	// ************************************************************
	// Debug multiplexer
	// ************************************************************
	// Status sampled every clock, so a new selector shows next cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_word_reg <= ZERO_WORD;
			wr_word_reg <= ZERO_WORD;
		end else begin
			rd_word_reg <= is_other(rsel_next) ? other_status_i : calib_status_i;
			wr_word_reg <= write_status_i;
		end
	end

	// Debug status write: wdata_i goes out registered every clock; a write to the debug write word adds a target pulse unless the target is none
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dbgw_reg <= ZERO_WORD;
			calw_reg <= 1'b0;
			othw_reg <= 1'b0;
		end else begin
			dbgw_reg <= wdata_i;
			calw_reg <= wr_i && hit(addr_i, OFF_DBG_WRITE) && wsel != SEL_NONE
				&& !is_other(wsel);
			othw_reg <= wr_i && hit(addr_i, OFF_DBG_WRITE) && is_other(wsel);
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	always_comb begin
		rdata_next = ZERO_WORD;
		if (hit(addr_i, OFF_NIBBLE_FIRST)) begin
			rdata_next[NC0_W-1:0] = nc0_reg;
		end else if (hit(addr_i, OFF_NIBBLE_SECOND)) begin
			rdata_next[NC1_W-1:0] = nc1_reg;
		end else if (hit(addr_i, OFF_CALIB)) begin
			rdata_next[CAL_W-1:0] = cal_reg;
		end else if (hit(addr_i, OFF_DBG_WRITE)) begin
			rdata_next = wr_word_reg;
		end else if (hit(addr_i, OFF_DBG_INDEX)) begin
			rdata_next = idx_reg;
		end else if (hit(addr_i, OFF_DBG_READ)) begin
			rdata_next = rd_word_reg;
		end else if (hit(addr_i, OFF_DBG_COUNTER)) begin
			rdata_next[CNT_GO] = go_reg;
		end else begin
			rdata_next = ZERO_WORD;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= ZERO_WORD;
		end else if (rd_i) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= ZERO_WORD;
		end
	end

	assign rdata_o                     = rdata_reg;
	assign dbg_wdata_o                 = dbgw_reg;
	assign dbg_calib_wr_o              = calw_reg;
	assign dbg_other_wr_o              = othw_reg;
	assign debug_write_target_select_o = wsel;
	assign debug_counter_go_o          = go_reg;
	assign pos_strobe_from_neighbour_o = nc0_reg[NC0_POS_NB];
	assign neg_strobe_from_neighbour_o = nc0_reg[NC0_NEG_NB];
	assign invert_rx_clock_o           = nc0_reg[NC0_INV_RX];
	assign serial_mode_o               = nc0_reg[NC0_SERIAL];
	assign tx_gating_off_o             = nc0_reg[NC0_TX_GATE];
	assign rx_gating_off_o             = nc0_reg[NC0_RX_GATE];
	assign rx_gate_extend_o            = nc0_reg[NC0_RXG_EXT];
	assign rx_phase_pos_o              = nc1_reg[NC1_PH_P];
	assign rx_phase_neg_o              = nc1_reg[NC1_PH_N];
	assign tx_phase_90_o               = nc1_reg[NC1_W-1:NC1_TX_LO];
	assign built_in_self_calibration_o = cal_reg[CAL_ON];
	assign input_drift_tracking_off_o  = cal_reg[CAL_IN_OFF];
	assign output_drift_tracking_off_o = cal_reg[CAL_OUT_OFF];

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_read_word_select: assert property (
		##1 $past(rsel_next[SEL_OTHER]) |-> rd_word_reg == $past(other_status_i))
		else $error("read word not from other source");
	a_read_word_calib: assert property (
		##1 !$past(rsel_next[SEL_OTHER]) |-> rd_word_reg == $past(calib_status_i))
		else $error("read word not from calibration source");
	a_counter_go: assert property (
		wr_i && addr_i == OFF_DBG_COUNTER |=> debug_counter_go_o == $past(wdata_i[CNT_GO]))
		else $error("counter bit not written");
	a_no_decode: assert property (
		wr_i && addr_i > OFF_DBG_COUNTER |=> $stable(nc0_reg) && $stable(idx_reg)
		&& $stable(go_reg) && $stable(cal_reg) && $stable(nc1_reg))
		else $error("unmapped write changed state");
	a_unmapped_read: assert property (
		rd_i && addr_i > OFF_DBG_COUNTER |=> rdata_o == ZERO_WORD)
		else $error("unmapped read not zero");
	a_write_none: assert property (
		wsel == SEL_NONE |=> !dbg_calib_wr_o && !dbg_other_wr_o)
		else $error("debug write with target zero");
	a_write_calib: assert property (
		wr_i && addr_i == OFF_DBG_WRITE && wsel != SEL_NONE && !wsel[SEL_OTHER]
		|=> dbg_calib_wr_o && !dbg_other_wr_o)
		else $error("calibration write missing");
	a_serial_revert: assert property (
		rdy_s2_reg && !rdy_s3_reg && !(wr_i && addr_i == OFF_NIBBLE_FIRST)
		|=> !serial_mode_o)
		else $error("serial bit kept after ready");
	a_calib_field: assert property (
		wr_i && addr_i == OFF_CALIB |=> built_in_self_calibration_o == $past(wdata_i[CAL_ON])
		&& input_drift_tracking_off_o == $past(wdata_i[CAL_IN_OFF]))
		else $error("calibration field mismatch");
	a_read_one_cycle: assert property (
		!rd_i |=> rdata_o == ZERO_WORD)
		else $error("read data outside read cycle");
	a_write_other: assert property (
		wr_i && addr_i == OFF_DBG_WRITE && wsel[SEL_OTHER]
		|=> dbg_other_wr_o && !dbg_calib_wr_o)
		else $error("other-module write missing");
	a_write_data: assert property (
		wr_i && addr_i == OFF_DBG_WRITE |=> dbg_wdata_o == $past(wdata_i))
		else $error("debug write data wrong");
	a_write_idle: assert property (
		!(wr_i && addr_i == OFF_DBG_WRITE) |=> !dbg_calib_wr_o && !dbg_other_wr_o)
		else $error("debug write pulse without request");
	a_index_write: assert property (
		wr_i && addr_i == OFF_DBG_INDEX
		|=> debug_write_target_select_o == $past(wdata_i[WR_SEL_HI:WR_SEL_LO]))
		else $error("write target not taken");
	a_index_hold: assert property (
		!(wr_i && addr_i == OFF_DBG_INDEX) |=> $stable(idx_reg))
		else $error("index changed without write");
	a_read_status: assert property (
		rd_i && addr_i == OFF_DBG_READ |=> rdata_o == $past(rd_word_reg))
		else $error("read word not returned");
	a_read_follows: assert property (
		wr_i && addr_i == OFF_DBG_INDEX ##1 rd_i && addr_i == OFF_DBG_READ
		|=> rdata_o == ($past(wdata_i[SEL_OTHER], 2) ? $past(other_status_i, 2)
		: $past(calib_status_i, 2)))
		else $error("read word missed new selector");
	a_write_word: assert property (
		rd_i && addr_i == OFF_DBG_WRITE |=> rdata_o == $past(write_status_i, 2))
		else $error("write word not returned");
	a_counter_read: assert property (
		rd_i && addr_i == OFF_DBG_COUNTER |=> rdata_o[CNT_GO] == $past(go_reg)
		&& rdata_o[DATA_W-1:CNT_GO+1] == '0)
		else $error("counter register reads wrong");
	a_counter_hold: assert property (
		!(wr_i && addr_i == OFF_DBG_COUNTER) |=> $stable(go_reg))
		else $error("counter bit changed without write");

	// ************************************************************
	// Control field assertions
	// ************************************************************
	a_pos_strobe: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> pos_strobe_from_neighbour_o == $past(wdata_i[NC0_POS_NB]))
		else $error("positive strobe source not written");
	a_neg_strobe: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> neg_strobe_from_neighbour_o == $past(wdata_i[NC0_NEG_NB]))
		else $error("negative strobe source not written");
	a_invert_clock: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> invert_rx_clock_o == $past(wdata_i[NC0_INV_RX]))
		else $error("receive clock invert not written");
	a_serial_write: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> serial_mode_o == $past(wdata_i[NC0_SERIAL]))
		else $error("serial sampling bit not written");
	a_tx_gating: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> tx_gating_off_o == $past(wdata_i[NC0_TX_GATE]))
		else $error("transmit gating bit not written");
	a_rx_gating: assert property (
		wr_i && addr_i == OFF_NIBBLE_FIRST
		|=> rx_gating_off_o == $past(wdata_i[NC0_RX_GATE]))
		else $error("receive gating bit not written");
	a_nibble_hold: assert property (
		!(wr_i && addr_i == OFF_NIBBLE_FIRST) && !(rdy_s2_reg && !rdy_s3_reg)
		|=> $stable(nc0_reg))
		else $error("nibble control changed without cause");
	a_rx_phase: assert property (
		wr_i && addr_i == OFF_NIBBLE_SECOND
		|=> rx_phase_pos_o == $past(wdata_i[NC1_PH_P])
		&& rx_phase_neg_o == $past(wdata_i[NC1_PH_N]))
		else $error("receive phase bits not written");
	a_tx_phase: assert property (
		wr_i && addr_i == OFF_NIBBLE_SECOND
		|=> tx_phase_90_o == $past(wdata_i[NC1_W-1:NC1_TX_LO]))
		else $error("transmit phase bits not written");
	a_phase_hold: assert property (
		!(wr_i && addr_i == OFF_NIBBLE_SECOND) |=> $stable(nc1_reg))
		else $error("phase control changed without write");
	a_output_track: assert property (
		wr_i && addr_i == OFF_CALIB
		|=> output_drift_tracking_off_o == $past(wdata_i[CAL_OUT_OFF]))
		else $error("output tracking bit not written");
	a_calib_hold: assert property (
		!(wr_i && addr_i == OFF_CALIB) |=> $stable(cal_reg))
		else $error("calibration control changed without write");

	c_read_status: cover property (rd_i && addr_i == OFF_DBG_READ ##1 rdata_o != ZERO_WORD);
	c_calib_write: cover property (dbg_calib_wr_o);
	c_other_write: cover property (dbg_other_wr_o);
	c_serial_revert: cover property (serial_mode_o ##1 !serial_mode_o);
	c_index_then_read: cover property (wr_i && addr_i == OFF_DBG_INDEX ##1 rd_i && addr_i == OFF_DBG_READ);
endmodule

// [testbench/ndcr_status_model.sv]
// Status source model standing beside the nibble debug register bank.
// Assumes one clock; words are fixed distinct patterns, zero in reset.
`timescale 1ns/100ps
module ndcr_status_model
	import ndcr_pkg::*;
#(
	parameter logic [DATA_W-1:0] CAL_WORD   = 16'hA5C3,
	parameter logic [DATA_W-1:0] OTHER_WORD = 16'h3C5A,
	parameter logic [DATA_W-1:0] WRITE_WORD = 16'h0FF1
)(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	output logic      [DATA_W-1:0] calib_status_o,
	output logic      [DATA_W-1:0] other_status_o,
	output logic      [DATA_W-1:0] write_status_o
);
	// ************************************************************
	// Status words
	// ************************************************************
	// Distinct patterns, so a wrong source select cannot read back right
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			calib_status_o <= 16'h0000;
			other_status_o <= 16'h0000;
			write_status_o <= 16'h0000;
		end else begin
			calib_status_o <= CAL_WORD;
			other_status_o <= OTHER_WORD;
			write_status_o <= WRITE_WORD;
		end
	end
endmodule

// [testbench/tb_nibble_debug_control_registers.sv]
// Self-checking bench for the nibble debug and control register bank.
// Assumes a 50 MHz clock and the plain strobe register port.
`timescale 1ns/100ps
module tb_nibble_debug_control_registers;
	import ndcr_pkg::*;
	localparam logic [15:0] CAL_PAT = 16'hA5C3;
	localparam logic [15:0] OTH_PAT = 16'h3C5A;
	localparam logic [15:0] WR_PAT  = 16'h0FF1;
	logic              clk, rst, wr, rd, flag;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, cal_st, oth_st, wr_st, dbg_wdata;
	logic              dbg_cal_wr, dbg_oth_wr, cnt_go, pos_nb, neg_nb, inv_rx, serial;
	logic              tx_off, rx_off, rx_ext, ph_p, ph_n, cal_on, in_off, out_off;
	logic [7:0]        wsel;
	logic [TX_COUNT-1:0] txph;
	logic [7:0]        sel_tab [5] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF};
	int                error_cnt, num_checks;

	ndcr_status_model #(.CAL_WORD(CAL_PAT), .OTHER_WORD(OTH_PAT), .WRITE_WORD(WR_PAT))
	ndcr_status_model_i (.clk_i(clk), .rst_i(rst), .calib_status_o(cal_st),
		.other_status_o(oth_st), .write_status_o(wr_st));

	ndcr_regs ndcr_regs_i (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .calib_status_i(cal_st),
		.other_status_i(oth_st), .write_status_i(wr_st), .delay_ready_flag_i(flag),
		.dbg_wdata_o(dbg_wdata), .dbg_calib_wr_o(dbg_cal_wr), .dbg_other_wr_o(dbg_oth_wr),
		.debug_write_target_select_o(wsel), .debug_counter_go_o(cnt_go),
		.pos_strobe_from_neighbour_o(pos_nb), .neg_strobe_from_neighbour_o(neg_nb),
		.invert_rx_clock_o(inv_rx), .serial_mode_o(serial), .tx_gating_off_o(tx_off),
		.rx_gating_off_o(rx_off), .rx_gate_extend_o(rx_ext), .rx_phase_pos_o(ph_p),
		.rx_phase_neg_o(ph_n), .tx_phase_90_o(txph), .built_in_self_calibration_o(cal_on),
		.input_drift_tracking_off_o(in_off), .output_drift_tracking_off_o(out_off));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stand one cycle only, then must fall back to zero
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
		@(posedge clk);
		#1;
		check(rdata, ZERO_WORD);
	endtask

	function automatic logic [15:0] nc0_v();
		return {9'h000, rx_ext, rx_off, tx_off, serial, inv_rx, neg_nb, pos_nb};
	endfunction

	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and sequence
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		int i;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		flag = 1'b0;
		addr = 6'h00;
		wdata = 16'h0000;
		error_cnt = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check({13'h0000, out_off, in_off, cal_on}, 16'h0001);
		rd_chk(OFF_NIBBLE_FIRST, 16'h0000);
		rd_chk(OFF_NIBBLE_SECOND, 16'h0000);
		rd_chk(OFF_CALIB, 16'h0001);
		rd_chk(OFF_DBG_INDEX, 16'h0000);
		rd_chk(OFF_DBG_COUNTER, 16'h0000);
		rd_chk(OFF_DBG_WRITE, WR_PAT);
		// Walking one through each control bit alone
		for (i = 0; i < 7; i++) begin
			wr_reg(OFF_NIBBLE_FIRST, 16'h0001 << i);
			check(nc0_v(), 16'h0001 << i);
		end
		wr_reg(OFF_NIBBLE_FIRST, 16'hFFFF);
		rd_chk(OFF_NIBBLE_FIRST, 16'h007F);
		wr_reg(OFF_NIBBLE_SECOND, 16'hFFFF);
		check({4'h0, txph, ph_n, ph_p}, 16'h0FFF);
		rd_chk(OFF_NIBBLE_SECOND, 16'h0FFF);
		wr_reg(OFF_NIBBLE_SECOND, 16'h0801);
		check({4'h0, txph, ph_n, ph_p}, 16'h0801);
		wr_reg(OFF_CALIB, 16'hFFFE);
		check({13'h0000, out_off, in_off, cal_on}, 16'h0006);
		rd_chk(OFF_CALIB, 16'h0006);
		wr_reg(OFF_DBG_COUNTER, 16'hFFFF);
		check({15'h0000, cnt_go}, 16'h0001);
		rd_chk(OFF_DBG_COUNTER, 16'h0001);
		// Undecoded and read-only places must swallow writes
		for (i = 0; i < 5; i++) begin
			wr_reg(6'h3B + 6'(i), 16'hFFFF);
			rd_chk(6'h3B + 6'(i), 16'h0000);
		end
		wr_reg(OFF_DBG_READ, 16'hFFFF);
		rd_chk(OFF_DBG_COUNTER, 16'h0001);
		rd_chk(OFF_DBG_INDEX, 16'h0000);
		rd_chk(OFF_NIBBLE_FIRST, 16'h007F);
		// Both selectors across their range boundaries
		for (i = 0; i < 5; i++) begin
			wr_reg(OFF_DBG_INDEX, {sel_tab[i], sel_tab[i]});
			check({8'h00, wsel}, {8'h00, sel_tab[i]});
			rd_chk(OFF_DBG_READ, sel_tab[i][7] ? OTH_PAT : CAL_PAT);
			wr_reg(OFF_DBG_WRITE, 16'(16'h1234 + i));
			check(dbg_wdata, 16'(16'h1234 + i));
			check({14'h0000, dbg_oth_wr, dbg_cal_wr},
				(sel_tab[i] == 8'h00) ? 16'h0000 : (sel_tab[i][7] ? 16'h0002 : 16'h0001));
			@(posedge clk);
			#1;
			check({14'h0000, dbg_oth_wr, dbg_cal_wr}, 16'h0000);
		end
		// Status read right behind an index write must see the new source
		@(posedge clk);
		addr <= OFF_DBG_INDEX;
		wdata <= 16'h0000;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= OFF_DBG_READ;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, CAL_PAT);
		// Serial sampling falls back on delay ready and must be rewritten
		wr_reg(OFF_NIBBLE_FIRST, 16'h0008);
		check({15'h0000, serial}, 16'h0001);
		@(posedge clk);
		flag <= 1'b1;
		for (i = 0; i < 8 && serial === 1'b1; i++) @(posedge clk);
		#1;
		check({15'h0000, serial}, 16'h0000);
		wr_reg(OFF_NIBBLE_FIRST, 16'h0008);
		check({15'h0000, serial}, 16'h0001);
		// Reset in mid-run returns every control field to its default
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check(nc0_v(), 16'h0000);
		check({4'h0, txph, ph_n, ph_p}, 16'h0000);
		check({13'h0000, out_off, in_off, cal_on}, 16'h0001);
		check({7'h00, cnt_go, wsel}, 16'h0000);
		give_verdict();
	end
endmodule
